// >>> sbac_bus_model.sv
/*
 * sbac_bus_model: the single-wire serial bus on the far side of the
 * arbiter counter, wired-and of our transmit pin and one other node,
 * plus an oscillator clock given as one-cycle enable pulses.
 * Assumes the bench drives it through its tasks after a clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module sbac_bus_model
(
    // clock
    input  wire logic clk_i,
    // bus side
    input  wire logic tx_pin_i,
    output wire logic rx_o,
    output wire logic osc_tick_o
);
    logic dom = 1'b0;
    logic osc_en = 1'b0;
    logic osc_q = 1'b0;

    // ----------------------------------------------------------------
    // line level
    // ----------------------------------------------------------------
    // recessive high via pull-up; any dominant node pulls the line low
    assign rx_o = tx_pin_i & ~dom;

    assign osc_tick_o = osc_q;
    // pulse every second bus clock so a wrong clock source shows up
    always @(posedge clk_i)
        osc_q <= osc_en & ~osc_q;

    task set_dom(input logic b);
        @(posedge clk_i);
        dom <= b;
    endtask : set_dom

    task set_osc(input logic b);
        @(posedge clk_i);
        osc_en <= b;
    endtask : set_osc

    // other node drives the line dominant for n cycles
    task pulse_low(input int n);
        @(posedge clk_i);
        dom <= 1'b1;
        repeat (n) @(posedge clk_i);
        dom <= 1'b0;
    endtask : pulse_low
endmodule : sbac_bus_model

`default_nettype wire

// >>> sbac_core.sv
/*
 * sbac_core: serial bus arbiter counter with a Wishbone register slave.
 * Watches the receive pin and the internal transmit signal, measures
 * bit times and checks bus arbitration.
 * Assumes rx_i and tx_int_i are synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module sbac_core
    import sbac_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // serial side
    input  wire logic        rx_i,
    input  wire logic        tx_int_i,
    input  wire logic        osc_tick_i,
    output logic             tx_o,
    // interrupt
    output logic             irq_o
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [1:0]       mode;
    logic             clk_sel;
    logic             osc_sel;
    logic [7:0]       psc_div;
    logic             lost;
    logic             done;
    logic             ovf;
    logic [CNT_W-1:0] cnt;
    logic [I_W-1:0]   stat;
    logic [I_W-1:0]   mask;
    logic             rx_q;
    logic             tx_q;
    logic             low_seen;
    sbac_state_e      state;
    sbac_state_e      next_state;

    sbac_tick_if tk ();

    function automatic logic hit(input logic [7:0] off);
        hit = (adr_i == off);
    endfunction : hit

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic req;
    logic wr;
    logic ctrl_wr;
    logic active;
    logic meas;
    logic arb;
    logic rx_fall;
    logic rx_rise;
    logic tx_rise;
    logic tx_fall;
    logic tick;
    logic wrap;
    logic set_done;
    logic set_lost;
    logic set_ovf;
    logic [8:0] sample_pt;
    logic [7:0] ctrl_rd;

    assign req     = cyc_i && stb_i && !ack_o;
    assign wr      = cyc_i && stb_i && ack_o && we_i && sel_i[0];
    assign ctrl_wr = wr && hit(OFF_CTRL);
    assign meas    = (mode == MODE_MEAS);
    assign arb     = (mode == MODE_ARB);
    assign active  = meas || arb;
    assign rx_fall = rx_q && !rx_i;
    assign rx_rise = !rx_q && rx_i;
    assign tx_rise = !tx_q && tx_int_i;
    assign tx_fall = tx_q && !tx_int_i;
    assign tick    = tk.tick;
    assign wrap    = (state == ST_RUN) && tick && (cnt == CNT_MAX);
    assign sample_pt = clk_sel ? SAMPLE_1 : SAMPLE_0;

    // ----------------------------------------------------------------
    // counter clock generator
    // ----------------------------------------------------------------
    assign tk.clk_sel  = clk_sel;
    assign tk.osc_sel  = osc_sel;
    assign tk.osc_tick = osc_tick_i;
    assign tk.psc_div  = psc_div;
    assign tk.clear    = (state != ST_RUN);

    sbac_tick u_tick (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .tk    (tk.gen)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        set_done   = 1'b0;
        case (state)
            ST_IDLE:
                if (active)
                    next_state = ST_WAIT;
            ST_WAIT:
                if (meas && !clk_sel && rx_fall)
                    next_state = ST_RUN;
                else if (meas && clk_sel && !rx_i)
                    next_state = ST_RUN;
                else if (arb && tx_rise)
                    next_state = ST_RUN;
            ST_RUN:
                if (meas && !clk_sel && rx_fall)
                begin
                    next_state = ST_DONE;
                    set_done   = 1'b1;
                end
                else if (meas && clk_sel && rx_rise)
                begin
                    next_state = ST_DONE;
                    set_done   = 1'b1;
                end
                else if (arb && tx_fall && !low_seen)
                    next_state = ST_WAIT;
            ST_DONE:
                next_state = ST_DONE;
            default:
                next_state = ST_IDLE;
        endcase
        if (!active)
            next_state = ST_IDLE;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state <= ST_IDLE;
        else if (ce_i && ctrl_wr)
            state <= (dat_i[7:6] == MODE_MEAS || dat_i[7:6] == MODE_ARB)
                     ? ST_WAIT : ST_IDLE;
        else if (ce_i)
            state <= next_state;
    end

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    // a control write always zeroes the counter, even mid count
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt <= '0;
        else if (ce_i)
        begin
            if (ctrl_wr || !active || state == ST_WAIT)
                cnt <= '0;
            else if (arb && tx_rise)
                cnt <= '0;
            else if (state == ST_RUN && tick)
                cnt <= cnt + 9'h001;
        end
    end

    // receive low seen since the last transmit rise
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            low_seen <= 1'b0;
        else if (ce_i)
            low_seen <= (arb && !tx_rise) && (low_seen || !rx_i);
    end

    // ----------------------------------------------------------------
    // flags; a hardware set beats a software clear
    // ----------------------------------------------------------------
    assign set_lost = arb && (state == ST_RUN) && tick
                      && (cnt == sample_pt) && !rx_i;
    assign set_ovf  = wrap;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            lost <= 1'b0;
        else if (ce_i && set_lost)
            lost <= 1'b1;
        else if (ce_i && ctrl_wr && !dat_i[B_MODE_HI])
            lost <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            done <= 1'b0;
        else if (ce_i && set_done)
            done <= 1'b1;
        else if (ce_i && ctrl_wr)
            done <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ovf <= 1'b0;
        else if (ce_i && set_ovf)
            ovf <= 1'b1;
        else if (ce_i && ctrl_wr)
            ovf <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_q <= 1'b1;
            tx_q <= 1'b1;
        end
        else if (ce_i)
        begin
            rx_q <= rx_i;
            tx_q <= tx_int_i;
        end
    end

    // lost arbitration holds the line recessive
    assign tx_o = tx_int_i || lost;

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode    <= MODE_IDLE;
            clk_sel <= 1'b0;
        end
        else if (ce_i && ctrl_wr)
        begin
            mode    <= dat_i[B_MODE_HI:B_MODE_LO];
            clk_sel <= dat_i[B_CLKSEL];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            osc_sel <= 1'b0;
            psc_div <= DIV_RST;
        end
        else if (ce_i && wr && hit(OFF_CFG))
        begin
            osc_sel <= dat_i[C_OSC];
            if (sel_i[1])
                psc_div <= dat_i[C_DIV_LO +: 8];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mask <= MASK_RST;
        else if (ce_i && wr && hit(OFF_MASK))
            mask <= dat_i[I_W-1:0];
    end

    // write one to clear; a new event in the same cycle stays set
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            stat <= '0;
        else if (ce_i)
            stat <= (stat & ~((wr && hit(OFF_STAT)) ? dat_i[I_W-1:0] : 3'h0))
                    | {set_ovf, set_lost, set_done};
    end

    assign irq_o = |(stat & mask);

    assign ctrl_rd = {mode, lost, clk_sel, done, (state == ST_RUN),
                      ovf, cnt[8]};

    // one wait state; a write lands at the edge where ack is sampled high
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            ack_o <= req;
            dat_o <= 32'h0000_0000;
            if (req && !we_i)
                case (adr_i)
                    OFF_CTRL:  dat_o <= {24'h000000, ctrl_rd};
                    OFF_COUNT: dat_o <= {24'h000000, cnt[7:0]};
                    OFF_STAT:  dat_o <= {29'h0, stat};
                    OFF_MASK:  dat_o <= {29'h0, mask};
                    OFF_CFG:   dat_o <= {16'h0000, psc_div, 7'h00, osc_sel};
                    default:   dat_o <= 32'h0000_0000;
                endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_meas0_start;
        ce_i && !ctrl_wr && meas && !clk_sel && state == ST_WAIT && rx_fall;
    endsequence

    a_idle_holds: assert property (ce_i && !ctrl_wr && !active |=> cnt == 0
        && state == ST_IDLE) else $error("counter not held in idle");
    a_meas_start: assert property (s_meas0_start |=> state == ST_RUN
        ##0 cnt == 0) else $error("measurement did not start");
    a_lost_set: assert property (ce_i && set_lost |=> lost [*1] ##0 tx_o)
        else $error("lost flag not set at sample point");
    a_lost_clear: assert property (ce_i && ctrl_wr && !dat_i[B_MODE_HI]
        && !set_lost |=> !lost) else $error("lost flag not cleared");
    a_tx_forced: assert property (lost |-> tx_o)
        else $error("transmit not forced high");
    a_ovf_wrap: assert property (ce_i && wrap && !ctrl_wr |=> ovf && cnt == 0)
        else $error("overflow not flagged");
    a_done_stop: assert property ($rose(done) && !$past(ctrl_wr) |-> state == ST_DONE
        && $past(state) == ST_RUN) else $error("done without stop");
    a_wr_clear: assert property (ce_i && ctrl_wr && !set_done && !set_ovf |=> cnt == 0
        && !done && !ovf) else $error("write did not clear");
    a_ack_pulse: assert property (ack_o && ce_i |=> !ack_o)
        else $error("ack held too long");
    a_meas1_stop: assert property (ce_i && !ctrl_wr && meas && clk_sel
        && state == ST_RUN && rx_rise |=> done) else $error("break end missed");

endmodule : sbac_core

`default_nettype wire

// >>> sbac_pkg.sv
/*
 * sbac_pkg: constants shared by the serial bus arbiter counter.
 * Assumes a 32-bit Wishbone register bus with byte addresses.
 */
`default_nettype none

package sbac_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_COUNT = 8'h04;
    localparam logic [7:0] OFF_STAT  = 8'h08;
    localparam logic [7:0] OFF_MASK  = 8'h0c;
    localparam logic [7:0] OFF_CFG   = 8'h10;

    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int B_MODE_HI = 7;
    localparam int B_MODE_LO = 6;
    localparam int B_LOST    = 5;
    localparam int B_CLKSEL  = 4;
    localparam int B_DONE    = 3;
    localparam int B_RUN     = 2;
    localparam int B_OVF     = 1;
    localparam int B_MSB     = 0;

    // interrupt status and mask fields
    localparam int I_DONE = 0;
    localparam int I_LOST = 1;
    localparam int I_OVF  = 2;
    localparam int I_W    = 3;

    // configuration fields: oscillator select and prescaler divisor
    localparam int C_OSC    = 0;
    localparam int C_DIV_LO = 8;

    // ----------------------------------------------------------------
    // mode encodings, counter and timing
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_IDLE = 2'h0;
    localparam logic [1:0] MODE_MEAS = 2'h1;
    localparam logic [1:0] MODE_ARB  = 2'h2;
    localparam logic [1:0] MODE_RSVD = 2'h3;

    localparam int         CNT_W     = 9;
    localparam logic [8:0] CNT_MAX   = 9'h1ff;
    localparam logic [8:0] SAMPLE_0  = 9'h038;
    localparam logic [8:0] SAMPLE_1  = 9'h008;
    localparam logic [1:0] QUART_MAX = 2'h3;
    localparam logic [7:0] DIV_RST   = 8'h00;
    localparam logic [I_W-1:0] MASK_RST = 3'h0;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN, ST_DONE} sbac_state_e;

endpackage : sbac_pkg

`default_nettype wire

// >>> sbac_tick.sv
/*
 * sbac_tick: counter clock enable for the arbiter counter, a quarter of
 * the bus clock or a quarter of the serial prescaler output.
 * Assumes the oscillator clock arrives as a pulse synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module sbac_tick
    import sbac_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // link to the core
    sbac_tick_if.gen  tk
);

    logic [7:0] psc_cnt;
    logic [1:0] quart;
    logic       psc_src;
    logic       psc_out;
    logic       step;

    // prescaler fed by the bus clock or the oscillator clock
    assign psc_src = tk.osc_sel ? tk.osc_tick : 1'b1;
    assign psc_out = psc_src && (psc_cnt == tk.psc_div);
    assign step    = tk.clk_sel ? psc_out : 1'b1;
    assign tk.tick = step && (quart == QUART_MAX);

    always_ff @(posedge clk_i)
    begin
        if (rst_i || (ce_i && tk.clear))
            psc_cnt <= 8'h00;
        else if (ce_i && psc_src)
            psc_cnt <= psc_out ? 8'h00 : psc_cnt + 8'h01;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || (ce_i && tk.clear))
            quart <= 2'h0;
        else if (ce_i && step)
            quart <= quart + 2'h1;
    end

endmodule : sbac_tick

`default_nettype wire

// >>> sbac_tick_if.sv
/*
 * sbac_tick_if: link between the arbiter core and its counter clock
 * generator. Assumes both ends share one clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface sbac_tick_if;
    logic       clk_sel;
    logic       osc_sel;
    logic       osc_tick;
    logic [7:0] psc_div;
    logic       clear;
    logic       tick;

    modport gen (input clk_sel, osc_sel, osc_tick, psc_div, clear, output tick);
    modport use_ (output clk_sel, osc_sel, osc_tick, psc_div, clear, input tick);
endinterface : sbac_tick_if

`default_nettype wire

// >>> testbench.sv
/*
 * testbench: self-checking bench for the arbiter counter core.
 * Assumes a 20 MHz bus clock and the register map of sbac_pkg.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import sbac_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        tx_int = 1'b1, tx_pin, rx, osc_tick, irq, ack, ce = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0, sel_v = 4'hf;
    logic [31:0] wdat = 32'h0, rdat, q;
    time         t0, t1;
    int          n_fail = 0, comparisons = 0, e, c1;

    always #25 clk = ~clk;

    sbac_core dut (.clk_i(clk), .rst_i(rst), .ce_i(ce), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .rx_i(rx), .tx_int_i(tx_int), .osc_tick_i(osc_tick), .tx_o(tx_pin), .irq_o(irq));
    sbac_bus_model model (.clk_i(clk), .tx_pin_i(tx_pin), .rx_o(rx), .osc_tick_o(osc_tick));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task wrap_up;
        $display("counts: %0d compared, %0d bad", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task cycles(input int n);
        repeat (n) @(posedge clk);
    endtask : cycles

    // one classic cycle; ack and read data are taken at the same edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= sel_v;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        if (n >= 20)
        begin
            n_fail++;
            wrap_up();
        end
    endtask : wb

    task rd_chk(input string name, input logic [7:0] a, input logic [31:0] m,
                input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check(name, q & m, exp);
    endtask : rd_chk

    // count over elapsed time, with slack for divider phase
    task cnt_chk(input int per);
        e = int'((t1 - t0) / (per * 50));
        wb(1'b0, OFF_COUNT, 32'h0);
        check("count range", {31'h0, (q >= e - 2 && q <= e + 1) === 1'b1}, 32'h1);
    endtask : cnt_chk

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_reset;
        rd_chk("ctrl rst", OFF_CTRL, 32'hffffffff, 32'h0);
        rd_chk("count rst", OFF_COUNT, 32'hffffffff, 32'h0);
        rd_chk("stat rst", OFF_STAT, 32'hffffffff, 32'h0);
        rd_chk("mask rst", OFF_MASK, 32'hffffffff, 32'h0);
        rd_chk("unmapped", 8'h3c, 32'hffffffff, 32'h0);
        check("irq rst", irq, 1'b0);
        wb(1'b1, OFF_COUNT, 32'hff);
        rd_chk("count ro", OFF_COUNT, 32'hffffffff, 32'h0);
        wb(1'b1, OFF_CTRL, 32'hff);
        rd_chk("ctrl ro bits", OFF_CTRL, 32'hffffffff, 32'hd0);
        wb(1'b1, OFF_CTRL, 32'h0);
        $display("test reset done");
    endtask : t_reset

    // byte lanes, then a frozen clock enable while the line toggles
    task t_lanes_freeze;
        sel_v = 4'he;
        wb(1'b1, OFF_CTRL, 32'h40);
        sel_v = 4'h1;
        wb(1'b1, OFF_CFG, 32'h0501);
        sel_v = 4'hf;
        rd_chk("ctrl lane0", OFF_CTRL, 32'hff, 32'h0);
        rd_chk("cfg lane1", OFF_CFG, 32'hffff, 32'h1);
        wb(1'b1, OFF_CFG, 32'h0300);
        rd_chk("cfg div", OFF_CFG, 32'hffff, 32'h300);
        wb(1'b1, OFF_CFG, 32'h0);
        wb(1'b1, OFF_CTRL, 32'h40);
        model.pulse_low(4);
        cycles(40);
        wb(1'b0, OFF_COUNT, 32'h0);
        c1 = q;
        @(posedge clk) ce <= 1'b0;
        model.pulse_low(10);
        cycles(100);
        ce <= 1'b1;
        wb(1'b0, OFF_COUNT, 32'h0);
        check("frozen count", {31'h0, (q >= c1 && q <= c1 + 2) === 1'b1}, 32'h1);
        rd_chk("frozen run", OFF_CTRL, 32'hff, 32'h44);
        wb(1'b1, OFF_CTRL, 32'h0);
        $display("test lanes and freeze done");
    endtask : t_lanes_freeze

    task t_meas0;
        wb(1'b1, OFF_MASK, 32'h7);
        wb(1'b1, OFF_CTRL, 32'h40);
        t0 = $time;
        model.pulse_low(10);
        cycles(150);
        rd_chk("running", OFF_CTRL, 32'hff, 32'h44);
        t1 = $time;
        model.pulse_low(10);
        cycles(4);
        cnt_chk(4);
        rd_chk("done ctrl", OFF_CTRL, 32'hff, 32'h48);
        rd_chk("done stat", OFF_STAT, 32'hff, 32'h1);
        check("irq set", irq, 1'b1);
        wb(1'b1, OFF_STAT, 32'h1);
        cycles(1);
        check("irq clr", irq, 1'b0);
        wb(1'b1, OFF_CTRL, 32'h0);
        rd_chk("ctrl clr", OFF_CTRL, 32'hff, 32'h0);
        rd_chk("count clr", OFF_COUNT, 32'hff, 32'h0);
        model.pulse_low(10);
        cycles(60);
        model.pulse_low(10);
        rd_chk("idle count", OFF_COUNT, 32'hff, 32'h0);
        wb(1'b1, OFF_CTRL, 32'hc0);
        model.pulse_low(10);
        cycles(60);
        model.pulse_low(10);
        cycles(4);
        rd_chk("rsvd ctrl", OFF_CTRL, 32'hff, 32'hc0);
        rd_chk("rsvd count", OFF_COUNT, 32'hff, 32'h0);
        rd_chk("rsvd stat", OFF_STAT, 32'hff, 32'h0);
        wb(1'b1, OFF_CTRL, 32'h0);
        $display("test bus clock measurement done");
    endtask : t_meas0

    task t_overflow;
        wb(1'b1, OFF_CTRL, 32'h40);
        model.pulse_low(4);
        cycles(1200);
        rd_chk("msb", OFF_CTRL, 32'hff, 32'h45);
        cycles(1000);
        rd_chk("ovf ctrl", OFF_CTRL, 32'hfe, 32'h46);
        rd_chk("ovf stat", OFF_STAT, 32'hff, 32'h4);
        wb(1'b1, OFF_MASK, 32'h3);
        cycles(1);
        check("irq masked", irq, 1'b0);
        wb(1'b1, OFF_STAT, 32'h4);
        wb(1'b1, OFF_MASK, 32'h7);
        wb(1'b1, OFF_CTRL, 32'h40);
        rd_chk("ovf clr", OFF_CTRL, 32'hff, 32'h40);
        rd_chk("cnt clr", OFF_COUNT, 32'hff, 32'h0);
        wb(1'b1, OFF_CTRL, 32'h0);
        $display("test overflow done");
    endtask : t_overflow

    task t_meas1;
        wb(1'b1, OFF_CFG, 32'h1);
        model.set_osc(1'b1);
        model.set_dom(1'b1);
        cycles(4);
        wb(1'b1, OFF_CTRL, 32'h50);
        t0 = $time;
        cycles(80);
        t1 = $time;
        model.set_dom(1'b0);
        cycles(4);
        cnt_chk(8);
        rd_chk("done ctrl1", OFF_CTRL, 32'hff, 32'h58);
        wb(1'b1, OFF_CTRL, 32'h0);
        wb(1'b1, OFF_STAT, 32'h7);
        wb(1'b1, OFF_CFG, 32'h0);
        model.set_osc(1'b0);
        $display("test prescaler measurement done");
    endtask : t_meas1

    task t_arb(input logic other, input logic [31:0] exp);
        wb(1'b1, OFF_CTRL, 32'h80);
        @(posedge clk) tx_int <= 1'b0;
        cycles(4);
        tx_int <= 1'b1;
        cycles(200);
        model.set_dom(other);
        cycles(60);
        model.set_dom(1'b0);
        cycles(2);
        rd_chk("arb ctrl", OFF_CTRL, 32'hfb, exp);
        tx_int <= 1'b0;
        cycles(1);
        check("tx pin", tx_pin, other);
        rd_chk("arb rerun", OFF_CTRL, 32'h4, {29'h0, other, 2'h0});
        rd_chk("arb stat", OFF_STAT, 32'h2, {30'h0, other, 1'b0});
        check("irq arb", irq, other);
        wb(1'b1, OFF_STAT, 32'h7);
        wb(1'b1, OFF_CTRL, 32'h0);
        rd_chk("lost clr", OFF_CTRL, 32'hff, 32'h0);
        check("tx free", tx_pin, 1'b0);
        tx_int <= 1'b1;
        $display("test arbitration done");
    endtask : t_arb

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        cycles(8);
        rst <= 1'b0;
        t_reset();
        t_lanes_freeze();
        t_meas0();
        t_overflow();
        t_meas1();
        t_arb(1'b1, 32'ha0);
        t_arb(1'b0, 32'h80);
        wrap_up();
    end
endmodule : testbench

`default_nettype wire
